// ### verilog/cmb_msr_bank.sv
// Purpose: Configuration and cache-init MSR bank
// Assumes: Plain register port, read data one cycle after strobe
// Notes: Unmapped reads return zero, unmapped writes are dropped
// What this block does
// - power-on bit 13 reads 1 for one-entry queue, 0 for eight
// - power-on bit 14 read-only, 1 means vector below 1 Mbyte
// - power-on bit 15 read-only, 1 means lockstep checking enabled
// - power-on bit 26 is writable low-power enable; 25, 63:27 reserved
// - test control bit 30 disables streaming, 31 suppresses split lock
// - four 64-bit chunk registers hold one cache line to or from L2
// - chunk 3 shares its address with the update signature register
// - L2 address uses bits 31:3; 2:0 written zero, 63:32 reserved
//
// Added by the designer: the plain strobed port.
`include "cmb_map.svh"
`timescale 1ns/1ns
`default_nettype none
module cmb_msr_bank #(
   parameter logic [63:0] MRCAP_VALUE = 64'h0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [11:0] addr_i,
   input wire logic [63:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [63:0] rdata_o,
   // Configuration straps
   input wire logic strap_ioq_one_i,
   input wire logic strap_vec_1m_i,
   input wire logic strap_lockstep_i,
   input wire logic [1:0] strap_cluster_i,
   input wire logic [1:0] strap_arb_i,
   input wire logic [2:0] strap_ratio_i,
   // Feature controls
   output logic low_power_en_o,
   output logic stream_buf_dis_o,
   output logic split_lock_suppress_o,
   output logic update_trigger_o,
   // L2 init path
   input wire logic chunk3_mode_i,
   input wire logic l2_load_i,
   input wire logic [255:0] l2_line_i,
   output logic [255:0] l2_line_o,
   output logic [31:0] l2_init_address_o,
   // Event counting
   input wire logic [1:0] perf_event_i
);

   cmb_strap_if st ();

   logic [3:0][63:0] chunk;
   logic [28:0] l2a;
   logic [63:0] trig_val;
   logic [1:0][63:0] perf;
   logic [63:0] poweron_view;
   logic [63:0] next_rdata;
   logic [3:0] wr_chunk;
   logic [1:0] wr_perf;
   logic wr_poweron;
   logic wr_test;
   logic wr_trig;
   logic wr_l2a;

   // Straps into the latch
   assign st.raw.ioq_one = strap_ioq_one_i;
   assign st.raw.vec_1m = strap_vec_1m_i;
   assign st.raw.lockstep = strap_lockstep_i;
   assign st.raw.cluster = strap_cluster_i;
   assign st.raw.arb = strap_arb_i;
   assign st.raw.ratio = strap_ratio_i;

   cmb_strap_latch u_strap (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .st (st.latch)
   );

   // Write decode
   assign wr_poweron = wr_i && (addr_i == `CMB_A_POWERON);
   assign wr_test = wr_i && (addr_i == `CMB_A_TEST_CONTROL);
   assign wr_trig = wr_i && (addr_i == `CMB_A_UPD_TRIG);
   assign wr_l2a = wr_i && (addr_i == `CMB_A_L2ADDR);
   assign wr_chunk[0] = wr_i && (addr_i == `CMB_A_CHUNK0);
   assign wr_chunk[1] = wr_i && (addr_i == `CMB_A_CHUNK1);
   assign wr_chunk[2] = wr_i && (addr_i == `CMB_A_CHUNK2);
   assign wr_chunk[3] = wr_i && (addr_i == `CMB_A_CHUNK3);
   assign wr_perf[0] = wr_i && (addr_i == `CMB_A_PERF0);
   assign wr_perf[1] = wr_i && (addr_i == `CMB_A_PERF1);

   // low-power enable
   // Only bit 26 of the word is kept
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_power_en_o <= `CMB_R_BIT;
      end else if (wr_poweron) begin
         low_power_en_o <= wdata_i[`CMB_P_LOWPWR];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stream_buf_dis_o <= `CMB_R_BIT;
         split_lock_suppress_o <= `CMB_R_BIT;
      end else if (wr_test) begin
         stream_buf_dis_o <= wdata_i[`CMB_P_STREAM_DIS];
         split_lock_suppress_o <= wdata_i[`CMB_P_SPLIT_LOCK];
      end
   end

   // Update trigger keeps the last word and pulses once per write
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_val <= `CMB_R_REG64;
      end else if (wr_trig) begin
         trig_val <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         update_trigger_o <= `CMB_R_BIT;
      end else begin
         update_trigger_o <= wr_trig;
      end
   end

   // chunk registers
   // An L2 return wins over a software write in the same cycle, since
   // losing the cache line would need a retry the host cannot see.
   // shared chunk 3
   // Signature use keeps the L2 return away from chunk 3.
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_chunk
         logic take_l2;
         assign take_l2 = l2_load_i && ((k != 3) || chunk3_mode_i);
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               chunk[k] <= `CMB_R_REG64;
            end else if (take_l2) begin
               chunk[k] <= l2_line_i[k*64 +: 64];
            end else if (wr_chunk[k]) begin
               chunk[k] <= wdata_i;
            end
         end
         assign l2_line_o[k*64 +: 64] = chunk[k];
      end
   endgenerate

   // L2 address
   // Low three bits are dropped, so they cannot reach the L2
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         l2a <= `CMB_R_L2A;
      end else if (wr_l2a) begin
         l2a <= wdata_i[`CMB_P_L2A_HI:`CMB_P_L2A_LO];
      end
   end

   assign l2_init_address_o = {l2a, 3'h0};

   cmb_event_counter #(
      .N (2),
      .W (64)
   ) u_perf (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .evt_i (perf_event_i),
      .wr_i (wr_perf),
      .wdata_i (wdata_i),
      .cnt_o (perf)
   );

   // strap fields read-only
   // Bits outside this bank's fields read as zero
   always_comb begin
      poweron_view = '0;
      poweron_view[`CMB_P_IOQ] = st.held.ioq_one;
      poweron_view[`CMB_P_RSTVEC] = st.held.vec_1m;
      poweron_view[`CMB_P_LOCKSTEP] = st.held.lockstep;
      poweron_view[`CMB_P_CLUSTER +: 2] = st.held.cluster;
      poweron_view[`CMB_P_ARB +: 2] = st.held.arb;
      poweron_view[`CMB_P_RATIO +: 3] = st.held.ratio;
      poweron_view[`CMB_P_LOWPWR] = low_power_en_o;
   end

   // Read mux
   always_comb begin
      next_rdata = '0;
      unique case (addr_i)
         `CMB_A_POWERON: next_rdata = poweron_view;
         `CMB_A_TEST_CONTROL: begin
            next_rdata[`CMB_P_STREAM_DIS] = stream_buf_dis_o;
            next_rdata[`CMB_P_SPLIT_LOCK] = split_lock_suppress_o;
         end
         `CMB_A_UPD_TRIG: next_rdata = trig_val;
         `CMB_A_CHUNK0: next_rdata = chunk[0];
         `CMB_A_CHUNK1: next_rdata = chunk[1];
         `CMB_A_CHUNK2: next_rdata = chunk[2];
         `CMB_A_CHUNK3: next_rdata = chunk[3];
         `CMB_A_PERF0: next_rdata = perf[0];
         `CMB_A_PERF1: next_rdata = perf[1];
         `CMB_A_MRCAP: next_rdata = MRCAP_VALUE;
         `CMB_A_L2ADDR: next_rdata[`CMB_P_L2A_HI:`CMB_P_L2A_LO] = l2a;
         default: next_rdata = '0;
      endcase
   end

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= `CMB_R_REG64;
      end else if (rd_i) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= `CMB_R_REG64;
      end
   end

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_rd_pwr;
      rd_i && (addr_i == `CMB_A_POWERON) && st.valid;
   endsequence

   sequence s_wr_c0;
      wr_i && (addr_i == `CMB_A_CHUNK0) && !l2_load_i;
   endsequence

   sequence s_rd_c0;
      rd_i && (addr_i == `CMB_A_CHUNK0) && !l2_load_i;
   endsequence

   sequence s_wr_pwr_rd;
      (wr_poweron && st.valid) ##1 !wr_i ##1 s_rd_pwr;
   endsequence

   sequence s_trig_once;
      wr_trig ##1 !wr_trig;
   endsequence

   a_ioq_depth_bit:
   assert property (s_rd_pwr |=> rdata_o[`CMB_P_IOQ] == $past(st.held.ioq_one))
   else $error("queue depth bit wrong");

   a_reset_vec_bit:
   assert property (s_wr_pwr_rd |=> rdata_o[`CMB_P_RSTVEC] == $past(st.held.vec_1m, 3))
   else $error("reset vector bit changed by write");

   a_lockstep_bit:
   assert property (s_rd_pwr |=> rdata_o[`CMB_P_LOCKSTEP] == st.held.lockstep)
   else $error("lockstep bit wrong");

   a_low_power_rw:
   assert property (wr_poweron ##1 !wr_i ##1 (rd_i && addr_i == `CMB_A_POWERON)
      |=> rdata_o[`CMB_P_LOWPWR] == $past(wdata_i[`CMB_P_LOWPWR], 3)
         && rdata_o[63:27] == 37'h0 && !rdata_o[25])
   else $error("low-power bit or reserved bits wrong");

   a_test_control_bits:
   assert property (wr_test |=> stream_buf_dis_o == $past(wdata_i[`CMB_P_STREAM_DIS])
      && split_lock_suppress_o == $past(wdata_i[`CMB_P_SPLIT_LOCK]))
   else $error("test control bits not taken");

   a_test_control_rsvd:
   assert property (rd_i && addr_i == `CMB_A_TEST_CONTROL |=> rdata_o[29:0] == 30'h0)
   else $error("test control reserved bits nonzero");

   a_chunk_readback:
   assert property (s_wr_c0 ##1 (!wr_i && !l2_load_i) ##1 s_rd_c0
      |=> rdata_o == $past(wdata_i, 3))
   else $error("chunk 0 readback mismatch");

   a_chunk3_shared:
   assert property (wr_chunk[3] && !(l2_load_i && chunk3_mode_i)
      |=> l2_line_o[255:192] == $past(wdata_i))
   else $error("chunk 3 write not seen");

   a_sig_kept:
   assert property (l2_load_i && !chunk3_mode_i && !wr_chunk[3]
      |=> $stable(l2_line_o[255:192]))
   else $error("signature overwritten by L2 return");

   a_l2_addr_fields:
   assert property (wr_l2a |=> l2_init_address_o == {$past(wdata_i[31:3]), 3'h0})
   else $error("L2 address fields wrong");

   a_strap_hold:
   assert property (st.valid |=> st.valid && $stable(st.held))
   else $error("latched straps changed");

   a_strap_fields_ro:
   assert property (s_wr_pwr_rd |=> rdata_o[24:13] == {$past(st.held.ratio, 3),
      $past(st.held.arb, 3), 2'h0, $past(st.held.cluster, 3), $past(st.held.lockstep, 3),
      $past(st.held.vec_1m, 3), $past(st.held.ioq_one, 3)})
   else $error("strap fields changed by write");

   a_low_power_pin:
   assert property (wr_poweron |=> low_power_en_o == $past(wdata_i[`CMB_P_LOWPWR]))
   else $error("low-power enable not taken");

   a_test_control_read:
   assert property (rd_i && addr_i == `CMB_A_TEST_CONTROL
      |=> rdata_o[31:30] == $past({split_lock_suppress_o, stream_buf_dis_o}))
   else $error("test control readback wrong");

   a_l2_load_low:
   assert property (l2_load_i |=> l2_line_o[191:0] == $past(l2_line_i[191:0]))
   else $error("L2 return not loaded");

   a_chunk3_read:
   assert property (rd_i && addr_i == `CMB_A_CHUNK3
      |=> rdata_o == $past(l2_line_o[255:192]))
   else $error("shared word readback wrong");

   a_l2_addr_read:
   assert property (rd_i && addr_i == `CMB_A_L2ADDR
      |=> rdata_o[63:32] == 32'h0 && rdata_o[2:0] == 3'h0)
   else $error("L2 address reserved bits nonzero");

   a_rdata_idle:
   assert property (!rd_i |=> rdata_o == `CMB_R_REG64)
   else $error("read data outside read cycle");

   a_mrcap_read:
   assert property (rd_i && addr_i == `CMB_A_MRCAP |=> rdata_o == MRCAP_VALUE)
   else $error("capability word wrong");

   a_trig_pulse:
   assert property (s_trig_once |-> update_trigger_o ##1 !update_trigger_o)
   else $error("update trigger pulse wrong");

   a_perf_step:
   assert property (perf_event_i[0] && !wr_perf[0] |=> perf[0] == $past(perf[0]) + 64'h1)
   else $error("counter 0 step wrong");

endmodule
`default_nettype wire

// ### verilog/cmb_map.svh
// Purpose: Offsets, field positions and reset values of the MSR bank
// Assumes: Register index is the plain 12-bit port address
// Notes: Included by bare name
`ifndef CMB_MAP_SVH
`define CMB_MAP_SVH
`define CMB_A_POWERON 12'h02a
`define CMB_A_TEST_CONTROL 12'h033
`define CMB_A_UPD_TRIG 12'h079
`define CMB_A_CHUNK0 12'h088
`define CMB_A_CHUNK1 12'h089
`define CMB_A_CHUNK2 12'h08a
`define CMB_A_CHUNK3 12'h08b
`define CMB_A_PERF0 12'h0c1
`define CMB_A_PERF1 12'h0c2
`define CMB_A_MRCAP 12'h0fe
`define CMB_A_L2ADDR 12'h116
`define CMB_P_IOQ 13
`define CMB_P_RSTVEC 14
`define CMB_P_LOCKSTEP 15
`define CMB_P_CLUSTER 16
`define CMB_P_ARB 20
`define CMB_P_RATIO 22
`define CMB_P_LOWPWR 26
`define CMB_P_STREAM_DIS 30
`define CMB_P_SPLIT_LOCK 31
`define CMB_P_L2A_LO 3
`define CMB_P_L2A_HI 31
`define CMB_R_BIT 1'b0
`define CMB_R_REG64 64'h0
`define CMB_R_L2A 29'h0
`endif

// ### verilog/cmb_pkg.sv
// Purpose: Shared types of the MSR bank
// Assumes: Nothing
// Notes: Constants live in cmb_map.svh
`default_nettype none
package cmb_pkg;
   typedef struct packed {
      logic ioq_one;
      logic vec_1m;
      logic lockstep;
      logic [1:0] cluster;
      logic [1:0] arb;
      logic [2:0] ratio;
   } cmb_strap_s;
   typedef enum {CMB_WAIT, CMB_HELD} cmb_cap_e;
endpackage
`default_nettype wire

// ### verilog/cmb_strap_if.sv
// Purpose: Carries raw and latched power-on straps
// Assumes: One latch, one user
// Notes: valid rises one edge after reset release
`timescale 1ns/1ns
`default_nettype none
interface cmb_strap_if;
   cmb_pkg::cmb_strap_s raw;
   cmb_pkg::cmb_strap_s held;
   logic valid;
   modport latch (input raw, output held, output valid);
   modport user (output raw, input held, input valid);
endinterface
`default_nettype wire

// ### verilog/cmb_strap_latch.sv
// Purpose: Captures the configuration straps once after reset
// Assumes: Straps are stable around reset release
// Notes: Values hold until the next reset
`timescale 1ns/1ns
`default_nettype none
module cmb_strap_latch (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Straps
   cmb_strap_if.latch st
);
   cmb_pkg::cmb_cap_e state;
   cmb_pkg::cmb_cap_e next_state;

   always_comb begin
      unique case (state)
         cmb_pkg::CMB_WAIT: next_state = cmb_pkg::CMB_HELD;
         cmb_pkg::CMB_HELD: next_state = cmb_pkg::CMB_HELD;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= cmb_pkg::CMB_WAIT;
      end else begin
         state <= next_state;
      end
   end

   // capture once
   // Reset loads a constant; straps are sampled on the first edge after
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st.held <= '0;
      end else if (state == cmb_pkg::CMB_WAIT) begin
         st.held <= st.raw;
      end
   end

   assign st.valid = (state == cmb_pkg::CMB_HELD);
endmodule
`default_nettype wire

// ### verilog/cmb_event_counter.sv
// Purpose: Software-writable event counters
// Assumes: One event pulse per cycle at most
// Notes: A write wins over a same-cycle increment
`timescale 1ns/1ns
`default_nettype none
module cmb_event_counter #(
   parameter int N = 2,
   parameter int W = 64
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Events and writes
   input wire logic [N-1:0] evt_i,
   input wire logic [N-1:0] wr_i,
   input wire logic [W-1:0] wdata_i,
   // Counts
   output logic [N-1:0][W-1:0] cnt_o
);
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_cnt
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               cnt_o[g] <= '0;
            end else if (wr_i[g]) begin
               cnt_o[g] <= wdata_i;
            end else if (evt_i[g]) begin
               cnt_o[g] <= cnt_o[g] + W'(1);
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Straps packed as queue, vector, lockstep, cluster, arb, ratio
`include "cmb_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
   // Arbitrary capability word, any value serves
   localparam logic [63:0] MRCAP = 64'h0000_0000_0000_0a05;
   localparam logic [63:0] ONES = 64'hffff_ffff_ffff_ffff;
   logic clk_i;
   logic rst_i;
   logic [11:0] addr_i;
   logic [63:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [63:0] rdata_o;
   logic [9:0] straps;
   logic low_power_en_o;
   logic stream_buf_dis_o;
   logic split_lock_suppress_o;
   logic update_trigger_o;
   logic chunk3_mode_i;
   logic l2_load_i;
   logic [255:0] l2_line_i;
   logic [255:0] l2_line_o;
   logic [31:0] l2_init_address_o;
   logic [1:0] perf_event_i;
   logic [255:0] ln;
   logic [9:0] s;
   int fails;
   int compares;
   int cyc;

   cmb_msr_bank #(.MRCAP_VALUE(MRCAP)) cmb_msr_bank_i (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .strap_ioq_one_i(straps[9]),
      .strap_vec_1m_i(straps[8]), .strap_lockstep_i(straps[7]),
      .strap_cluster_i(straps[6:5]), .strap_arb_i(straps[4:3]),
      .strap_ratio_i(straps[2:0]), .low_power_en_o(low_power_en_o),
      .stream_buf_dis_o(stream_buf_dis_o), .split_lock_suppress_o(split_lock_suppress_o),
      .update_trigger_o(update_trigger_o), .chunk3_mode_i(chunk3_mode_i),
      .l2_load_i(l2_load_i), .l2_line_i(l2_line_i), .l2_line_o(l2_line_o),
      .l2_init_address_o(l2_init_address_o), .perf_event_i(perf_event_i)
   );

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // Hang guard, the whole run needs about 82 cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         report_and_stop();
      end
   end

   function automatic logic [63:0] pwr(input logic [9:0] v, input logic lp);
      pwr = 64'h0;
      pwr[15:13] = {v[7], v[8], v[9]};
      pwr[17:16] = v[6:5];
      pwr[21:20] = v[4:3];
      pwr[24:22] = v[2:0];
      pwr[26] = lp;
   endfunction

   function automatic logic [63:0] pat(input int k);
      pat = {16{4'(k + 1)}};
   endfunction

   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [63:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rchk(input string n, input logic [11:0] a, input logic [63:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(n, e, rdata_o);
   endtask

   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      fails = 0;
      compares = 0;
      cyc = 0;
      rst_i = 1'b1;
      addr_i = 12'h0;
      wdata_i = 64'h0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      chunk3_mode_i = 1'b1;
      l2_load_i = 1'b0;
      l2_line_i = 256'h0;
      perf_event_i = 2'b00;
      straps = 10'h0;
      for (int i = 0; i < 2; i++) begin
         s = (i == 0) ? 10'b1_1_1_10_01_101 : 10'b0_0_0_01_10_010;
         straps = s;
         do_reset();
         chk("low_power_rst", 64'h0, {63'h0, low_power_en_o});
         rchk("poweron", `CMB_A_POWERON, pwr(s, 1'b0));
         wr(`CMB_A_POWERON, ONES);
         straps = ~s;
         chk("low_power", 64'h1, {63'h0, low_power_en_o});
         rchk("poweron_w", `CMB_A_POWERON, pwr(s, 1'b1));
      end
      $display("test straps done");
      wr(`CMB_A_TEST_CONTROL, ONES);
      chk("split_lock", 64'h1, {63'h0, split_lock_suppress_o});
      rchk("test_control", `CMB_A_TEST_CONTROL, 64'h0000_0000_c000_0000);
      wr(`CMB_A_TEST_CONTROL, 64'h0000_0000_4000_0000);
      chk("stream", 64'h1, {63'h0, stream_buf_dis_o});
      chk("split_clr", 64'h0, {63'h0, split_lock_suppress_o});
      $display("test control done");
      for (int k = 0; k < 4; k++) begin
         wr(12'(`CMB_A_CHUNK0 + k), pat(k));
         ln[k*64+:64] = pat(k);
         rchk("chunk", 12'(`CMB_A_CHUNK0 + k), pat(k));
      end
      chk("line_lo", ln[127:0], l2_line_o[127:0]);
      chk("line_hi", ln[255:128], l2_line_o[255:128]);
      // Signature mode must leave the shared fourth word alone
      chunk3_mode_i <= 1'b0;
      @(posedge clk_i);
      l2_load_i <= 1'b1;
      l2_line_i <= ~ln;
      @(posedge clk_i);
      l2_load_i <= 1'b0;
      #1;
      chk("load_sig", ~ln[191:128], l2_line_o[191:128]);
      chk("keep_sig", ln[255:192], l2_line_o[255:192]);
      rchk("signature", `CMB_A_CHUNK3, pat(3));
      chunk3_mode_i <= 1'b1;
      @(posedge clk_i);
      l2_load_i <= 1'b1;
      @(posedge clk_i);
      l2_load_i <= 1'b0;
      #1;
      chk("load_c3", ~ln[255:192], l2_line_o[255:192]);
      rchk("chunk3", `CMB_A_CHUNK3, ~pat(3));
      $display("test chunks done");
      wr(`CMB_A_L2ADDR, 64'hffff_ffff_ffff_fff8);
      chk("l2_addr_out", 64'hffff_fff8, {32'h0, l2_init_address_o});
      rchk("l2_addr", `CMB_A_L2ADDR, 64'h0000_0000_ffff_fff8);
      $display("test l2 address done");
      wr(`CMB_A_UPD_TRIG, 64'h0000_0000_0000_1234);
      chk("trig_on", 64'h1, {63'h0, update_trigger_o});
      @(posedge clk_i);
      #1;
      chk("trig_off", 64'h0, {63'h0, update_trigger_o});
      rchk("trig", `CMB_A_UPD_TRIG, 64'h0000_0000_0000_1234);
      wr(`CMB_A_MRCAP, ONES);
      rchk("mrcap", `CMB_A_MRCAP, MRCAP);
      wr(12'h3ff, ONES);
      rchk("unmapped", 12'h3ff, 64'h0);
      $display("test misc done");
      wr(`CMB_A_PERF0, 64'hffff_ffff_ffff_fffe);
      wr(`CMB_A_PERF1, 64'h0000_0000_0000_0005);
      @(posedge clk_i);
      perf_event_i <= 2'b11;
      repeat (2) @(posedge clk_i);
      perf_event_i <= 2'b00;
      rchk("perf0", `CMB_A_PERF0, 64'h0);
      rchk("perf1", `CMB_A_PERF1, 64'h0000_0000_0000_0007);
      $display("test counters done");
      report_and_stop();
   end
endmodule
`default_nettype wire
